/* File: tac_pkg.sv */
package tac_pkg;
	// Register byte offsets
	localparam logic [31:0] CFG_OFF     = 32'h0011_4000;
	localparam logic [31:0] CTRL_OFF    = 32'h0011_4004;
	localparam logic [31:0] TRIG_OFF    = 32'h0011_4008;
	localparam logic [31:0] PULSE_OFF   = 32'h0011_400c;
	localparam logic [31:0] STATUS_OFF  = 32'h0011_4010;
	localparam logic [31:0] IRQ_STS_OFF = 32'h0011_4014;
	localparam logic [31:0] IRQ_CLR_OFF = 32'h0011_4018;
	localparam logic [31:0] IRQ_EN_OFF  = 32'h0011_401c;
	// Config field positions
	localparam int TRIG_MODE_LSB = 0;
	localparam int REPEAT_BIT    = 2;
	localparam int SRC_BIT       = 3;
	localparam int UPD_BIT       = 4;
	// Control bits (write-one)
	localparam int START_BIT = 0;
	localparam int STOP_BIT  = 1;
	// Reset values
	localparam logic [31:0] CFG_RST   = 32'h0000_0000;
	localparam logic [31:0] TRIG_RST  = 32'h0000_0000;
	localparam logic [31:0] PULSE_RST = 32'h0000_0000;
	// Trigger modes
	typedef enum logic [1:0] {
		TAC_ABS  = 2'b00,
		TAC_REL  = 2'b01,
		TAC_COMB = 2'b10,
		TAC_RSVD = 2'b11
	} tac_mode_t;
	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* File: tac_alarm.sv */
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
// What this block does
// - The count is taken from timer one when the source selector is 0, timer two when 1.
// - Repeat selector 0 fires once then stops, 1 fires repeatedly.
// - Mode 00 fires when the selected count equals the trigger value.
// - Mode 01 fires when the count has advanced by the trigger value.
// - Mode 10 fires first by equality then by advance; code 11 is reserved.
// - With update requested, new trigger and pulse values load at the next firing.
// - Start enables the channel, loads current values and begins relative counting.
// - Firing raises an interrupt event and drives the pin high for the pulse duration, or for one cycle when that duration is zero.
module tac_alarm #(
	parameter int CW = 32
) (
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic [CW-1:0] timer1_count,
	input  wire logic [CW-1:0] timer2_count,
	input  wire logic [31:0]   s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [31:0]   s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	output logic               alarm_pin,
	output logic               irq
);
	// Counts wider than the register word cannot be programmed
	if (CW < 1 || CW > 32) begin
		$error("CW must be 1..32");
	end

	logic [31:0]   cfg;
	logic [31:0]   trig_reg;
	logic [31:0]   pulse_reg;
	logic [CW-1:0] act_trig;
	logic [31:0]   act_pulse;
	logic          active;
	logic          first_done;
	logic [CW-1:0] base;
	logic [31:0]   pulse_cnt;
	logic          irq_sts;
	logic          irq_en;
	logic [31:0]   aw_addr;
	logic [31:0]   w_data;
	logic [3:0]    w_strb;
	logic          aw_have;
	logic          w_have;

	// Byte-lane merge for register writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) r[i*8 +: 8] = d[i*8 +: 8];
		end
		return r;
	endfunction

	// Selected timer count
	logic [CW-1:0] count;
	assign count = cfg[tac_pkg::SRC_BIT] ? timer2_count : timer1_count;

	// Write channel capture, address and data in either order
	logic wr_go;
	assign wr_go = aw_have && w_have && !s_axi_bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have <= 1'b0;
			w_have <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_addr <= 32'h0000_0000;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have <= 1'b1;
				s_axi_awready <= 1'b0; // Ready is a flop, always the inverse of the hold flag
				aw_addr <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_have <= 1'b0;
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have <= 1'b1;
				s_axi_wready <= 1'b0;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_go) begin
				w_have <= 1'b0;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Decode of a completed write
	logic wr_ctrl;
	logic start_wr;
	logic stop_wr;
	logic wr_known;
	assign wr_ctrl = wr_go && aw_addr == tac_pkg::CTRL_OFF && w_strb[0];
	assign start_wr = wr_ctrl && w_data[tac_pkg::START_BIT];
	assign stop_wr = wr_ctrl && w_data[tac_pkg::STOP_BIT];
	assign wr_known = aw_addr inside {tac_pkg::CFG_OFF, tac_pkg::CTRL_OFF, tac_pkg::TRIG_OFF,
		tac_pkg::PULSE_OFF, tac_pkg::STATUS_OFF, tac_pkg::IRQ_STS_OFF,
		tac_pkg::IRQ_CLR_OFF, tac_pkg::IRQ_EN_OFF};

	// Write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= tac_pkg::RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_known ? tac_pkg::RESP_OKAY : tac_pkg::RESP_SLVERR;
		end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
	end

	// Alarm condition per mode; combination uses equality until first firing
	tac_pkg::tac_mode_t mode;
	logic               fire;
	assign mode = tac_pkg::tac_mode_t'(cfg[tac_pkg::TRIG_MODE_LSB +: 2]);
	always_comb begin
		fire = 1'b0;
		case (mode)
			tac_pkg::TAC_ABS:  fire = count == act_trig;
			tac_pkg::TAC_REL:  fire = CW'(count - base) == act_trig;
			tac_pkg::TAC_COMB: fire = first_done ? (CW'(count - base) == act_trig)
				: (count == act_trig);
			default:           fire = 1'b0; // Reserved code never fires
		endcase
		fire = fire && active && !start_wr;
	end

	// Software registers; update flag is consumed when it is applied
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg <= tac_pkg::CFG_RST;
			trig_reg <= tac_pkg::TRIG_RST;
			pulse_reg <= tac_pkg::PULSE_RST;
			irq_en <= 1'b0;
		end else begin
			if (wr_go && aw_addr == tac_pkg::CFG_OFF) cfg <= merge(cfg, w_data, w_strb) & 32'h1f;
			else if (fire && cfg[tac_pkg::UPD_BIT]) cfg[tac_pkg::UPD_BIT] <= 1'b0;
			if (wr_go && aw_addr == tac_pkg::TRIG_OFF) trig_reg <= merge(trig_reg, w_data, w_strb);
			if (wr_go && aw_addr == tac_pkg::PULSE_OFF)
				pulse_reg <= merge(pulse_reg, w_data, w_strb);
			if (wr_go && aw_addr == tac_pkg::IRQ_EN_OFF && w_strb[0]) irq_en <= w_data[0];
		end
	end

	// Channel run state and applied values
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			active <= 1'b0;
			first_done <= 1'b0;
			base <= '0;
			act_trig <= '0;
			act_pulse <= 32'h0000_0000;
		end else if (start_wr) begin
			active <= 1'b1;
			first_done <= 1'b0;
			base <= count; // Relative counting starts now
			act_trig <= trig_reg[CW-1:0];
			act_pulse <= pulse_reg;
		end else if (stop_wr) begin
			active <= 1'b0;
		end else if (fire) begin
			first_done <= 1'b1;
			base <= count; // Next relative interval from this firing
			if (!cfg[tac_pkg::REPEAT_BIT]) active <= 1'b0; // Single shot
			if (cfg[tac_pkg::UPD_BIT]) begin
				act_trig <= trig_reg[CW-1:0];
				act_pulse <= pulse_reg;
			end
		end
	end

	// Pin pulse; a zero duration still gives one cycle so the edge is seen
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			alarm_pin <= 1'b0;
			pulse_cnt <= 32'h0000_0000;
		end else if (fire) begin
			alarm_pin <= 1'b1;
			pulse_cnt <= (act_pulse > 32'h1) ? act_pulse - 32'h1 : 32'h0;
		end else if (pulse_cnt != 32'h0) begin
			pulse_cnt <= pulse_cnt - 32'h1;
		end else alarm_pin <= 1'b0;
	end

	// Sticky event; a new firing wins over a clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_sts <= 1'b0;
			irq <= 1'b0;
		end else begin
			if (fire) irq_sts <= 1'b1;
			else if (wr_go && aw_addr == tac_pkg::IRQ_CLR_OFF && w_strb[0] && w_data[0])
				irq_sts <= 1'b0;
			irq <= (irq_sts || fire) && irq_en;
		end
	end

	// Read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= tac_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_arready <= 1'b0; // One read at a time
			s_axi_rresp <= tac_pkg::RESP_OKAY;
			case (s_axi_araddr)
				tac_pkg::CFG_OFF:     s_axi_rdata <= cfg;
				tac_pkg::CTRL_OFF:    s_axi_rdata <= 32'h0000_0000;
				tac_pkg::TRIG_OFF:    s_axi_rdata <= trig_reg;
				tac_pkg::PULSE_OFF:   s_axi_rdata <= pulse_reg;
				tac_pkg::STATUS_OFF:  s_axi_rdata <= {31'h0, active};
				tac_pkg::IRQ_STS_OFF: s_axi_rdata <= {31'h0, irq_sts};
				tac_pkg::IRQ_CLR_OFF: s_axi_rdata <= 32'h0000_0000;
				tac_pkg::IRQ_EN_OFF:  s_axi_rdata <= {31'h0, irq_en};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= tac_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Checks
	AST_SINGLE_STOPS: assert property (@(posedge aclk) disable iff (!aresetn)
		fire && !cfg[tac_pkg::REPEAT_BIT] && !stop_wr |=> !active)
		else $error("single mode stayed active");
	AST_CONT_STAYS: assert property (@(posedge aclk) disable iff (!aresetn)
		fire && cfg[tac_pkg::REPEAT_BIT] && !stop_wr |=> active)
		else $error("continuous mode stopped");
	AST_ABS_FIRE: assert property (@(posedge aclk) disable iff (!aresetn)
		active && !start_wr && mode == tac_pkg::TAC_ABS && count == act_trig |-> fire)
		else $error("absolute match missed");
	AST_REL_FIRE: assert property (@(posedge aclk) disable iff (!aresetn)
		active && !start_wr && mode == tac_pkg::TAC_REL && CW'(count - base) == act_trig
		|=> alarm_pin && irq_sts)
		else $error("relative advance missed");
	AST_RSVD: assert property (@(posedge aclk) disable iff (!aresetn)
		mode == tac_pkg::TAC_RSVD && !alarm_pin |=> !alarm_pin)
		else $error("reserved mode fired");
	AST_START: assert property (@(posedge aclk) disable iff (!aresetn)
		start_wr |=> active && act_trig == $past(trig_reg[CW-1:0]))
		else $error("start did not load");
	AST_PIN: assert property (@(posedge aclk) disable iff (!aresetn)
		fire |=> alarm_pin)
		else $error("pin not raised");
	AST_IRQ_STS: assert property (@(posedge aclk) disable iff (!aresetn)
		fire |=> irq_sts)
		else $error("event not latched");
	AST_NO_EARLY_UPD: assert property (@(posedge aclk) disable iff (!aresetn)
		!fire && !start_wr |=> $stable(act_trig))
		else $error("trigger changed outside firing");
	AST_SRC: assert property (@(posedge aclk) disable iff (!aresetn)
		start_wr && cfg[tac_pkg::SRC_BIT] |=> base == $past(timer2_count))
		else $error("wrong timer source");
endmodule

/* File: tac_timer_model.sv */
`timescale 1ns/1ps
// Stand-in for the two general-purpose timers, both counting up every cycle
module tac_timer_model (
	input  wire logic        aclk,
	input  wire logic        restart,
	output logic      [31:0] timer1_count,
	output logic      [31:0] timer2_count
);
	// Offset keeps the sources apart, so a wrong source pick never matches
	always_ff @(posedge aclk) begin
		if (restart) begin
			timer1_count <= 32'h0000_0000;
			timer2_count <= 32'h4000_0000;
		end else begin
			timer1_count <= timer1_count + 32'h1;
			timer2_count <= timer2_count + 32'h1;
		end
	end
endmodule

/* File: test_timer_alarm_channel_config.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module test_timer_alarm_channel_config;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic        restart = 1'b1;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, alarm_pin, irq, ok;
	logic [1:0]  bresp, rresp, r, wb;
	logic [31:0] rdata, d, trg, rc1, rc2, timer1_count, timer2_count;
	int          failures = 0, checks_done = 0, cyc = 0, rcyc, wid, pw, t0;
	localparam logic [31:0] OFFS [6] = '{tac_pkg::CFG_OFF, tac_pkg::TRIG_OFF, tac_pkg::PULSE_OFF,
		tac_pkg::STATUS_OFF, tac_pkg::IRQ_STS_OFF, tac_pkg::IRQ_EN_OFF};

	// Clock and cycle count
	always #5 aclk = ~aclk;
	always @(posedge aclk) cyc <= cyc + 1;

	tac_timer_model tm_u (.aclk(aclk), .restart(restart), .timer1_count(timer1_count),
		.timer2_count(timer2_count));
	tac_alarm dut_u (.aclk(aclk), .aresetn(aresetn), .timer1_count(timer1_count),
		.timer2_count(timer2_count), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.alarm_pin(alarm_pin), .irq(irq));

	// Handshakes judged from the settled values just before each rising edge
	task automatic axw(input logic [31:0] a, input logic [31:0] v);
		logic aw, w, hb;
		aw = 1'b1;
		w = 1'b1;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge aclk);
			hb = bvalid;
			wb = bresp;
			if (awready) aw = 1'b0;
			if (wready) w = 1'b0;
			@(posedge aclk);
			if (!aw) awvalid <= 1'b0;
			if (!w) wvalid <= 1'b0;
		end while (!hb);
		bready <= 1'b0;
	endtask

	task automatic axr(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
		logic ar, hr;
		ar = 1'b1;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge aclk);
			hr = rvalid;
			v = rdata;
			rs = rresp;
			if (arready) ar = 1'b0;
			@(posedge aclk);
			if (!ar) arvalid <= 1'b0;
		end while (!hr);
		rready <= 1'b0;
	endtask

	// Next pin rise: counts seen then, cycle of it, and how long it stays high
	task automatic wait_rise(input int lim, output logic found);
		int n;
		logic p;
		n = 0;
		p = 1'b1;
		found = 1'b0;
		while (!found && n < lim) begin
			@(negedge aclk);
			found = (alarm_pin === 1'b1) && !p;
			p = alarm_pin;
			n++;
		end
		rc1 = timer1_count;
		rc2 = timer2_count;
		rcyc = cyc;
		wid = 0;
		while (found && alarm_pin === 1'b1 && wid < 300) begin
			wid++;
			@(negedge aclk);
		end
	endtask

	task automatic tally_and_finish;
		$display("checks_done=%0d failures=%0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// Watchdog far beyond the several hundred cycles the run needs
	initial begin
		#300000;
		failures++;
		tally_and_finish();
	end

	initial begin
		void'($urandom(86806));
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		restart <= 1'b0;
		foreach (OFFS[i]) begin
			axr(OFFS[i], d, r);
			`CHK(d, 32'h0)
		end
		axr(32'h0011_4020, d, r);
		`CHK(r, tac_pkg::RESP_SLVERR)
		axw(32'h0011_4020, 32'h1);
		`CHK(wb, tac_pkg::RESP_SLVERR)
		// Single absolute shot from each source, interrupt still masked
		for (int s = 0; s < 2; s++) begin
			pw = $urandom % 8;
			trg = (s ? timer2_count : timer1_count) + 32'd60;
			axw(tac_pkg::CFG_OFF, 32'(s) << tac_pkg::SRC_BIT);
			axw(tac_pkg::TRIG_OFF, trg);
			axw(tac_pkg::PULSE_OFF, 32'(pw));
			axw(tac_pkg::CTRL_OFF, 32'h1);
			wait_rise(200, ok);
			`CHK(ok, 1'b1)
			`CHK(s ? rc2 : rc1, trg + 32'd1)
			`CHK(wid, (pw > 0) ? pw : 1)
			axr(tac_pkg::STATUS_OFF, d, r);
			`CHK(d[0], 1'b0)
			axr(tac_pkg::IRQ_STS_OFF, d, r);
			`CHK(d[0], 1'b1)
			@(negedge aclk);
			`CHK(irq, 1'b0)
		end
		axw(tac_pkg::IRQ_EN_OFF, 32'h1);
		`CHK(wb, tac_pkg::RESP_OKAY)
		@(negedge aclk);
		`CHK(irq, 1'b1)
		axw(tac_pkg::IRQ_CLR_OFF, 32'h1);
		@(negedge aclk);
		`CHK(irq, 1'b0)
		// Reserved mode must stay silent
		axw(tac_pkg::CFG_OFF, 32'h3);
		axw(tac_pkg::CTRL_OFF, 32'h1);
		wait_rise(100, ok);
		`CHK(ok, 1'b0)
		axw(tac_pkg::CTRL_OFF, 32'h2);
		// Continuous relative and combination, then a deferred trigger change
		for (int m = 1; m < 3; m++) begin
			trg = 32'd30 + 32'($urandom % 16);
			pw = $urandom % 8;
			axw(tac_pkg::CFG_OFF, 32'(m) | 32'h4);
			axw(tac_pkg::TRIG_OFF, trg);
			axw(tac_pkg::PULSE_OFF, 32'(pw));
			@(posedge aclk) restart <= 1'b1;
			@(posedge aclk) restart <= 1'b0;
			axw(tac_pkg::CTRL_OFF, 32'h1);
			wait_rise(200, ok);
			if (m == 2) `CHK(rc1, trg + 32'd1)
			t0 = rcyc;
			wait_rise(200, ok);
			`CHK(32'(rcyc - t0), trg)
			`CHK(wid, (pw > 0) ? pw : 1)
			axr(tac_pkg::STATUS_OFF, d, r);
			`CHK(d[0], 1'b1)
			t0 = rcyc;
			axw(tac_pkg::TRIG_OFF, trg + 32'd5);
			axw(tac_pkg::CFG_OFF, 32'(m) | 32'h14);
			wait_rise(200, ok);
			`CHK(32'(rcyc - t0), trg)
			t0 = rcyc;
			wait_rise(200, ok);
			`CHK(32'(rcyc - t0), trg + 32'd5)
			axw(tac_pkg::CTRL_OFF, 32'h2);
			axr(tac_pkg::STATUS_OFF, d, r);
			`CHK(d[0], 1'b0)
		end
		tally_and_finish();
	end
endmodule
